// [logic/ata_register_access_port.sv]
/*
 * Drive register access engine: holding pair, address/control register,
 * PIO sector counter and the parallel register cycle sequencer.
 * Assumes a synchronous MCU write/read port on mclk and a drive on pins.
 */
`timescale 1ns/1ps
`default_nettype none
module ata_register_access_port (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // mcu register port
    input wire logic [15:0] mcu_addr,
    input wire logic mcu_wr,
    input wire logic [7:0] mcu_wdata,
    output logic [7:0] mcu_rdata,
    // sector datapath
    input wire logic sector_done,
    output logic sector_fifo_flush,
    // drive bus pins
    output logic drive_cs0_n,
    output logic drive_cs1_n,
    output logic [2:0] drive_addr,
    output logic drive_rd_n,
    output logic drive_wr_n,
    input wire logic [15:0] drive_data_in,
    output logic [15:0] drive_data_out,
    output logic drive_data_oe,
    output logic drive_wide
);
    // ****************************************
    // mcu register file
    // ****************************************
    logic [7:0] hold_lo_q, hold_lo_d, hold_hi_q, hold_hi_d;
    logic [3:0] drive_reg_select_q, drive_reg_select_d;
    logic bus_read_trigger_q, bus_read_trigger_d;
    logic bus_write_trigger_q, bus_write_trigger_d;
    logic flush_q, flush_d;
    logic [8:0] pio_sector_counter_q, pio_sector_counter_d;
    logic [15:0] din_s1_q, din_s2_q;
    logic cyc_done;
    logic cyc_is_read_q, cyc_is_read_d;
    logic [15:0] rd_cap_q, rd_cap_d;
    logic ctrl_wr;

    assign ctrl_wr = mcu_wr && (mcu_addr == ata_access_pkg::ADDR_ADDR_CTRL);
    assign sector_fifo_flush = flush_q;

    always_comb
    begin
        hold_lo_d = hold_lo_q;
        hold_hi_d = hold_hi_q;
        drive_reg_select_d = drive_reg_select_q;
        bus_read_trigger_d = bus_read_trigger_q;
        bus_write_trigger_d = bus_write_trigger_q;
        flush_d = 1'b0; // see RL4
        pio_sector_counter_d = pio_sector_counter_q;
        if (mcu_wr && mcu_addr == ata_access_pkg::ADDR_DATA_LOW)
            hold_lo_d = mcu_wdata;
        if (mcu_wr && mcu_addr == ata_access_pkg::ADDR_DATA_HIGH)
            hold_hi_d = mcu_wdata;
        // clear ahead of the mcu update, so a trigger written in the same cycle survives
        if (cyc_done)
        begin
            bus_read_trigger_d = 1'b0; // see RL7
            bus_write_trigger_d = 1'b0; // see RL7
        end
        if (ctrl_wr)
        begin
            drive_reg_select_d = mcu_wdata[ata_access_pkg::SEL_LSB +: 4];
            // triggers are set-only from the mcu; zero writes do nothing
            if (mcu_wdata[ata_access_pkg::RD_TRIG_BIT])
                bus_read_trigger_d = 1'b1; // see RL6
            if (mcu_wdata[ata_access_pkg::WR_TRIG_BIT])
                bus_write_trigger_d = 1'b1; // see RL9
            flush_d = mcu_wdata[ata_access_pkg::FLUSH_BIT]; // see RL4
        end
        // load from byte count bits 17:9 (bit 9..15 in reg 1 bits 1..7)
        if (mcu_wr && mcu_addr == ata_access_pkg::ADDR_BCNT_1)
            pio_sector_counter_d[6:0] = mcu_wdata[7:1]; // see RL17
        else if (mcu_wr && mcu_addr == ata_access_pkg::ADDR_BCNT_2)
            pio_sector_counter_d[8:7] = mcu_wdata[1:0]; // see RL17
        else if (sector_done && pio_sector_counter_q != ata_access_pkg::SECT_RESET)
            pio_sector_counter_d = pio_sector_counter_q - 9'h001; // see RL16
        if (cyc_done && cyc_is_read_q)
        begin
            hold_lo_d = rd_cap_q[7:0]; // see RL2 RL7
            // high byte only meaningful for the data register
            hold_hi_d = rd_cap_q[15:8]; // see RL2
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            hold_lo_q <= ata_access_pkg::HOLD_RESET;
            hold_hi_q <= ata_access_pkg::HOLD_RESET;
            drive_reg_select_q <= ata_access_pkg::SEL_RESET;
            bus_read_trigger_q <= 1'b0;
            bus_write_trigger_q <= 1'b0;
            flush_q <= 1'b0;
            pio_sector_counter_q <= ata_access_pkg::SECT_RESET;
            din_s1_q <= 16'h0000;
            din_s2_q <= 16'h0000;
        end
        else
        begin
            hold_lo_q <= hold_lo_d;
            hold_hi_q <= hold_hi_d;
            drive_reg_select_q <= drive_reg_select_d;
            bus_read_trigger_q <= bus_read_trigger_d;
            bus_write_trigger_q <= bus_write_trigger_d;
            flush_q <= flush_d;
            pio_sector_counter_q <= pio_sector_counter_d;
            din_s1_q <= drive_data_in;
            din_s2_q <= din_s1_q;
        end
    end

    always_comb
    begin
        case (mcu_addr)
            ata_access_pkg::ADDR_DATA_LOW: mcu_rdata = hold_lo_q;
            ata_access_pkg::ADDR_DATA_HIGH: mcu_rdata = hold_hi_q;
            ata_access_pkg::ADDR_ADDR_CTRL:
                mcu_rdata = {drive_reg_select_q, bus_write_trigger_q, bus_read_trigger_q,
                             flush_q, pio_sector_counter_q[8]}; // see RL10
            ata_access_pkg::ADDR_SECT_LOW: mcu_rdata = pio_sector_counter_q[7:0];
            default: mcu_rdata = 8'h00;
        endcase
    end

    // ****************************************
    // drive register cycle sequencer
    // ****************************************
    ata_access_pkg::cycle_state_t state_q, state_d;
    logic [5:0] cnt_q, cnt_d;
    logic [2:0] addr_q, addr_d;
    logic cs0_q, cs0_d, cs1_q, cs1_d, rd_q, rd_d, wr_q, wr_d, oe_q, oe_d, wide_q, wide_d;
    logic [15:0] dout_q, dout_d;

    assign cyc_done = (state_q == ata_access_pkg::ST_RECOVER) && (cnt_q == 6'h00);

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        cs0_d = cs0_q;
        cs1_d = cs1_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        oe_d = oe_q;
        wide_d = wide_q;
        dout_d = dout_q;
        cyc_is_read_d = cyc_is_read_q;
        rd_cap_d = rd_cap_q;
        case (state_q)
            ata_access_pkg::ST_IDLE:
            begin
                // reserved selects are decoded like any other address
                if (bus_read_trigger_q || bus_write_trigger_q) // see RL14
                begin
                    cyc_is_read_d = bus_read_trigger_q; // see RL8
                    cs0_d = !drive_reg_select_q[ata_access_pkg::BLOCK_BIT]; // see RL11
                    cs1_d = drive_reg_select_q[ata_access_pkg::BLOCK_BIT]; // see RL11
                    addr_d = drive_reg_select_q[2:0]; // see RL12
                    wide_d = !drive_reg_select_q[ata_access_pkg::BLOCK_BIT]
                             && drive_reg_select_q[2:0] == ata_access_pkg::DATA_REG_SEL; // see RL3, RL13
                    dout_d = {hold_hi_q, hold_lo_q}; // see RL1
                    oe_d = !bus_read_trigger_q;
                    cnt_d = 6'(ata_access_pkg::SETUP_CYC - 1);
                    state_d = ata_access_pkg::ST_SETUP; // see RL18
                end
            end
            ata_access_pkg::ST_SETUP:
            begin
                if (cnt_q == 6'h00)
                begin
                    cnt_d = 6'(ata_access_pkg::STROBE_CYC - 1);
                    rd_d = cyc_is_read_q;
                    wr_d = !cyc_is_read_q;
                    state_d = ata_access_pkg::ST_STROBE; // see RL18
                end
                else
                    cnt_d = cnt_q - 6'h01;
            end
            ata_access_pkg::ST_STROBE:
            begin
                if (cnt_q == 6'h00)
                begin
                    cnt_d = 6'(ata_access_pkg::RECOVER_CYC + 1);
                    state_d = ata_access_pkg::ST_RECOVER;
                    // drive lets go of the bus soon after the strobe rises, so latch now
                    if (cyc_is_read_q)
                        rd_cap_d = din_s2_q; // see RL2
                end
                else
                begin
                    cnt_d = cnt_q - 6'h01;
                    rd_d = cyc_is_read_q;
                    wr_d = !cyc_is_read_q;
                end
            end
            ata_access_pkg::ST_RECOVER:
            begin
                // two spare recovery cycles keep the select well past the strobe
                if (cnt_q == 6'h00)
                begin
                    cs0_d = 1'b0;
                    cs1_d = 1'b0;
                    oe_d = 1'b0;
                    state_d = ata_access_pkg::ST_IDLE;
                end
                else
                    cnt_d = cnt_q - 6'h01;
            end
            default: state_d = ata_access_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_q <= ata_access_pkg::ST_IDLE;
            cnt_q <= 6'h00;
            addr_q <= 3'h0;
            cs0_q <= 1'b0;
            cs1_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            oe_q <= 1'b0;
            wide_q <= 1'b0;
            dout_q <= 16'h0000;
            cyc_is_read_q <= 1'b0;
            rd_cap_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            cs0_q <= cs0_d;
            cs1_q <= cs1_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            oe_q <= oe_d;
            wide_q <= wide_d;
            dout_q <= dout_d;
            cyc_is_read_q <= cyc_is_read_d;
            rd_cap_q <= rd_cap_d;
        end
    end

    assign drive_cs0_n = !cs0_q;
    assign drive_cs1_n = !cs1_q;
    assign drive_addr = addr_q;
    assign drive_rd_n = !rd_q;
    assign drive_wr_n = !wr_q;
    assign drive_data_out = dout_q;
    assign drive_data_oe = oe_q;
    assign drive_wide = wide_q;
endmodule : ata_register_access_port
`default_nettype wire

// [logic/ata_access_pkg.sv]
/*
 * Constants for the drive register access port: register addresses,
 * field positions, reset values and bus cycle timing.
 * Assumes a 100 MHz system clock and an 8-bit MCU data space.
 */
// Notes on behaviour
// RL1: register write drives holding pair, low byte first register, high byte second.
// RL2: read result lands in holding pair; only low byte valid except data register.
// RL3: data register uses 16-bit bus access, all other registers 8-bit.
// RL4: flush bit empties sector fifo and buffers, then clears itself next cycle.
// RL5: firmware flushes sector fifo after any abnormally ended transfer.
// RL6: read trigger starts a read cycle, stays set until done, then clears.
// RL7: read completion clears both triggers and stores captured value.
// RL8: read and write triggers set together: only the read is performed.
// RL9: write trigger starts write cycle from holding pair, clears when done.
// RL10: bit 0 of address/control shows sector counter bit 8, read only.
// RL11: address bit 3 clear selects command block, set selects control block.
// RL12: low three address bits pick the register inside the selected block.
// RL13: decode follows the command and control block register map.
// RL14: reserved drive addresses are not blocked; they run like any access.
// RL15: firmware avoids reserved drive addresses unless doing vendor functions.
// RL16: sector counter decrements by one after each full sector transfer.
// RL17: byte count load sets sector counter from byte count bits 17 to 9.
// RL18: each cycle drives chip select and address, then pulses read or write strobe.
`default_nettype none
package ata_access_pkg;
    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [15:0] ADDR_DATA_LOW = 16'hf0d2;
    localparam logic [15:0] ADDR_DATA_HIGH = 16'hf0d3;
    localparam logic [15:0] ADDR_ADDR_CTRL = 16'hf0d4;
    localparam logic [15:0] ADDR_SECT_LOW = 16'hf0d5;
    localparam logic [15:0] ADDR_BCNT_1 = 16'hf0d7;
    localparam logic [15:0] ADDR_BCNT_2 = 16'hf0d8;
    // ****************************************
    // address/control fields
    // ****************************************
    localparam int SECT_MSB_BIT = 0;
    localparam int FLUSH_BIT = 1;
    localparam int RD_TRIG_BIT = 2;
    localparam int WR_TRIG_BIT = 3;
    localparam int SEL_LSB = 4;
    localparam int BLOCK_BIT = 3;
    localparam logic [2:0] DATA_REG_SEL = 3'h0;
    localparam logic [7:0] HOLD_RESET = 8'h00;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [8:0] SECT_RESET = 9'h000;
    // ****************************************
    // register cycle timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS = 70;
    localparam int STROBE_NS = 290;
    localparam int RECOVER_NS = 30;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_RECOVER = 4'b1000
    } cycle_state_t;
endpackage : ata_access_pkg
`default_nettype wire

// [dv/ata_access_properties.sv]
/* checker for the drive register port pins and flush pulse.
   bound into ata_register_access_port; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module ata_access_properties (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // mcu side
    input wire logic [15:0] mcu_addr,
    input wire logic mcu_wr,
    input wire logic [7:0] mcu_wdata,
    input wire logic sector_fifo_flush,
    // drive pins
    input wire logic drive_cs0_n,
    input wire logic drive_cs1_n,
    input wire logic [2:0] drive_addr,
    input wire logic drive_rd_n,
    input wire logic drive_wr_n,
    input wire logic [15:0] drive_data_out,
    input wire logic drive_data_oe,
    input wire logic drive_wide
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic stb;
    logic cs;
    assign stb = drive_rd_n & drive_wr_n;
    assign cs = !drive_cs0_n || !drive_cs1_n;
    // ****************
    // assertions
    // ****************
    a_flush_pulse: assert property (
        mcu_wr && mcu_addr == ata_access_pkg::ADDR_ADDR_CTRL && mcu_wdata[1]
        |=> sector_fifo_flush ##1 !sector_fifo_flush) else $error("flush pulse");
    a_flush_cause: assert property (
        sector_fifo_flush |-> $past(mcu_wr && mcu_addr == ata_access_pkg::ADDR_ADDR_CTRL
        && mcu_wdata[1])) else $error("stray flush");
    a_one_strobe: assert property (
        drive_rd_n || drive_wr_n) else $error("both strobes low");
    a_one_select: assert property (
        drive_cs0_n || drive_cs1_n) else $error("both selects low");
    a_strobe_setup: assert property (
        $fell(stb) |-> $past(cs, 6)) else $error("select setup short");
    a_strobe_width: assert property (
        $fell(stb) |-> ##28 !stb ##1 stb) else $error("strobe width");
    a_addr_hold: assert property (
        !stb |-> cs && $stable(drive_addr) && $stable(drive_wide)) else $error("addr moved");
    a_wide_data: assert property (
        !stb |-> drive_wide == (!drive_cs0_n && drive_addr == 3'h0)) else $error("width");
    a_write_drive: assert property (
        !drive_wr_n |-> drive_data_oe && $stable(drive_data_out)) else $error("write data");
    a_read_float: assert property (
        !drive_rd_n |-> !drive_data_oe) else $error("driving on read");
    a_cycle_end: assert property (
        $rose(stb) |-> ##[1:10] !cs) else $error("select not released");
    c_read: cover property ($fell(drive_rd_n));
    c_write: cover property ($fell(drive_wr_n));
    c_flush: cover property (sector_fifo_flush);
endmodule : ata_access_properties
bind ata_register_access_port ata_access_properties props_inst (
    .mclk, .rst, .mcu_addr, .mcu_wr, .mcu_wdata, .sector_fifo_flush,
    .drive_cs0_n, .drive_cs1_n, .drive_addr, .drive_rd_n, .drive_wr_n,
    .drive_data_out, .drive_data_oe, .drive_wide
);
`default_nettype wire

// [dv/ata_drive_model.sv]
/* behavioural storage drive on the parallel register bus.
   assumes registered pins from the access port on mclk. */
`timescale 1ns/1ps
`default_nettype none
module ata_drive_model (
    // clock
    input wire logic mclk,
    // drive bus
    input wire logic drive_cs0_n,
    input wire logic drive_cs1_n,
    input wire logic [2:0] drive_addr,
    input wire logic drive_rd_n,
    input wire logic drive_wr_n,
    input wire logic drive_wide,
    input wire logic [15:0] drive_data_out,
    output logic [15:0] drive_data_in
);
    logic [15:0] regs [16];
    logic [15:0] last_q;
    logic [3:0] idx;
    logic one_cs;
    assign one_cs = drive_cs0_n ^ drive_cs1_n;
    assign idx = {!drive_cs1_n, drive_addr};
    // reserved slots stored like any other; narrow writes keep low lanes only
    always @(posedge drive_wr_n)
        if (one_cs)
            regs[idx] <= {drive_wide ? drive_data_out[15:8] : 8'h00, drive_data_out[7:0]};
    // released bus toggles so a late sample never matches by luck
    assign drive_data_in = (!drive_rd_n && one_cs) ? regs[idx] : ~last_q;
    always @(posedge mclk)
        last_q <= drive_data_in;
    initial
    begin
        last_q = 16'h0000;
        foreach (regs[i])
            regs[i] = 16'h0000;
    end
endmodule : ata_drive_model
`default_nettype wire

// [dv/ata_register_access_port_tb.sv]
/* self-checking bench for the drive register access port.
   assumes the drive model and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module ata_register_access_port_tb;
    logic mclk, rst, mcu_wr, sector_done, sector_fifo_flush;
    logic [15:0] mcu_addr, drive_data_in, drive_data_out;
    logic [7:0] mcu_wdata, mcu_rdata, v;
    logic drive_cs0_n, drive_cs1_n, drive_rd_n, drive_wr_n, drive_data_oe, drive_wide;
    logic [2:0] drive_addr;
    int failures, comparisons;
    ata_register_access_port ata_register_access_port_inst (
        .mclk, .rst, .mcu_addr, .mcu_wr, .mcu_wdata, .mcu_rdata, .sector_done,
        .sector_fifo_flush, .drive_cs0_n, .drive_cs1_n, .drive_addr, .drive_rd_n,
        .drive_wr_n, .drive_data_in, .drive_data_out, .drive_data_oe, .drive_wide
    );
    ata_drive_model ata_drive_model_inst (
        .mclk, .drive_cs0_n, .drive_cs1_n, .drive_addr, .drive_rd_n, .drive_wr_n,
        .drive_wide, .drive_data_out, .drive_data_in
    );
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ****************
    // access tasks
    // ****************
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        mcu_addr <= a;
        mcu_wdata <= d;
        mcu_wr <= 1'b1;
        @(posedge mclk);
        mcu_wr <= 1'b0;
    endtask : wr
    task automatic chk_rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        mcu_addr <= a;
        @(negedge mclk);
        v = mcu_rdata;
        `CHK(v & m, e)
    endtask : chk_rd
    // start a bus cycle and poll until both triggers drop
    task automatic run(input logic [7:0] c);
        int n;
        wr(16'hf0d4, c);
        chk_rd(16'hf0d4, 8'h0c, c & 8'h0c);
        for (n = 0; n < 200 && v[3:2] !== 2'b00; n++)
            chk_rd(16'hf0d4, 8'hf0, c & 8'hf0);
        `CHK(v[3:2], 2'b00)
    endtask : run
    task automatic end_sim;
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        end_sim;
    end
    initial
    begin
        mcu_addr = 16'h0000;
        mcu_wr = 1'b0;
        mcu_wdata = 8'h00;
        sector_done = 1'b0;
        rst = 1'b1;
        failures = 0;
        comparisons = 0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        chk_rd(16'hf0d2, 8'hff, 8'h00);
        chk_rd(16'hf0d3, 8'hff, 8'h00);
        chk_rd(16'hf0d4, 8'hff, 8'h00);
        chk_rd(16'hf0d6, 8'hff, 8'h00);
        for (int s = 0; s < 16; s++)
        begin
            wr(16'hf0d2, 8'h50 + 8'(s));
            wr(16'hf0d3, 8'ha0 + 8'(s));
            run({4'(s), 4'h8});
            `CHK(ata_drive_model_inst.regs[s], {(s == 0) ? 8'ha0 : 8'h00, 8'h50 + 8'(s)})
        end
        wr(16'hf0d2, 8'h00);
        wr(16'hf0d3, 8'h00);
        for (int s = 0; s < 16; s++)
        begin
            run({4'(s), 4'h4});
            chk_rd(16'hf0d2, 8'hff, 8'h50 + 8'(s));
            if (s == 0)
                chk_rd(16'hf0d3, 8'hff, 8'ha0);
        end
        wr(16'hf0d2, 8'h77);
        run(8'h3c);
        `CHK(ata_drive_model_inst.regs[3], 16'h0053)
        chk_rd(16'hf0d2, 8'hff, 8'h53);
        wr(16'hf0d4, 8'h02);
        #1 `CHK(sector_fifo_flush, 1'b1)
        @(posedge mclk);
        #1 `CHK(sector_fifo_flush, 1'b0)
        chk_rd(16'hf0d4, 8'h02, 8'h00);
        wr(16'hf0d8, 8'h02);
        wr(16'hf0d7, 8'h02);
        chk_rd(16'hf0d4, 8'h01, 8'h01);
        chk_rd(16'hf0d5, 8'hff, 8'h01);
        repeat (2)
        begin
            @(posedge mclk);
            sector_done <= 1'b1;
            @(posedge mclk);
            sector_done <= 1'b0;
        end
        chk_rd(16'hf0d4, 8'h01, 8'h00);
        chk_rd(16'hf0d5, 8'hff, 8'hff);
        end_sim;
    end
endmodule : ata_register_access_port_tb
`default_nettype wire
